//--- hw/timer_mode_control.v
// Mode control of a 16-bit timer/event counter with an APB register slave.
// Assumes a single core_clk at 250 MHz and an ext_timer_input synchronous to it.
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "timer_mode_defs.vh"

// Operation
// - Eight-bit mode register, byte or bit writes
// - Mode register resets to zero, counter stopped
// - Counting follows nonzero mode, stops at zero
// - Mode decode: stop, free, edge-clear, match-clear
// - Output toggles on either compare match
// - Option adds external edge as toggle source
// - Counter wrap from maximum sets overflow
// - Overflow cleared by writing zero or stopping
// - Stopping clears the counter to zero
// - Prescaler bits 5 and 4 pick edge
module timer_mode_control (
   // Clock and reset.
   input wire core_clk,
   input wire resetn,
   // APB slave.
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // Timer pins.
   input wire ext_timer_input,
   output reg timer_output,
   // Interrupt.
   output wire irq
);

   // Register state.
   reg [1:0] op_mode_r;
   reg out_toggle_cond_r;
   reg overflow_flag_r;
   reg [15:0] compare_reg_a_r;
   reg [15:0] compare_reg_b_r;
   reg [7:0] prescaler_mode_reg_r;
   reg [15:0] timer_count_r;

   // Next values and decoded strobes.
   reg [1:0] op_mode_nxt;
   reg out_toggle_cond_nxt;
   reg overflow_flag_nxt;
   reg [15:0] timer_count_nxt;
   reg [7:0] mode_wval;
   reg [31:0] rdata_nxt;
   reg addr_hit;
   reg timer_output_nxt;
   reg edge_clr_mode;
   reg match_clr_mode;

   wire [7:0] mode_byte;
   wire setup_ph;
   wire wr_en;
   wire mode_wr;
   wire bitop_wr;
   wire [2:0] bitop_idx;
   wire mode_any_wr;
   wire cmp_a_wr;
   wire cmp_b_wr;
   wire prescaler_wr;
   wire irq_clr_wr;
   wire irq_en_wr;
   wire rd_setup;
   wire [1:0] edge_sel;
   wire [15:0] count_inc;
   wire at_max;
   wire stop_next;
   wire running;
   wire edge_evt;
   wire match_a;
   wire match_b;
   wire clear_evt;
   wire wrap_evt;
   wire edge_toggle;
   wire toggle_evt;
   wire [`EV_COUNT-1:0] events;
   wire [`EV_COUNT-1:0] irq_status;
   wire [`EV_COUNT-1:0] irq_enable;

   // APB decode.

   // The slave never inserts wait states, so every access completes in its first access cycle.
   assign pready = 1'b1;
   assign setup_ph = psel & ~penable;
   assign wr_en = psel & penable & pwrite & addr_hit;
   // An unmapped address answers with an error and changes no register.
   assign pslverr = psel & penable & ~addr_hit;

   assign mode_wr = wr_en && (paddr == `ADDR_MODE_CTRL);
   assign bitop_wr = wr_en && (paddr == `ADDR_MODE_BITOP);
   assign bitop_idx = pwdata[`BITOP_IDX_HI:0];
   assign mode_any_wr = mode_wr || bitop_wr;

   // One strobe per register keeps every address compare in this one place.
   assign cmp_a_wr = wr_en && (paddr == `ADDR_CMP_A);
   assign cmp_b_wr = wr_en && (paddr == `ADDR_CMP_B);
   assign prescaler_wr = wr_en && (paddr == `ADDR_PRESCALER);
   assign irq_clr_wr = wr_en && (paddr == `ADDR_IRQ_CLEAR);
   assign irq_en_wr = wr_en && (paddr == `ADDR_IRQ_ENABLE);
   // Read data is loaded in the setup cycle, so a fast-moving value such as the
   // running count is reported as it stood one cycle before the access edge.
   assign rd_setup = setup_ph && !pwrite;

   always @* begin
      case (paddr)
         `ADDR_MODE_CTRL,
         `ADDR_MODE_BITOP,
         `ADDR_CMP_A,
         `ADDR_CMP_B,
         `ADDR_PRESCALER,
         `ADDR_COUNT,
         `ADDR_IRQ_STATUS,
         `ADDR_IRQ_CLEAR,
         `ADDR_IRQ_ENABLE: addr_hit = 1'b1;
         default: addr_hit = 1'b0;
      endcase
   end

   // Mode control register.

   // Bits 7..4 do not exist and read as zero.
   assign mode_byte = {4'h0, op_mode_r, out_toggle_cond_r, overflow_flag_r};

   // A byte write replaces the register; a bit write changes one bit of the current
   // value, which is how software alters a single field without a read-modify-write.
   always @* begin
      mode_wval = mode_byte;
      if (mode_wr)
         mode_wval = pwdata[7:0];
      else if (bitop_wr)
         mode_wval[bitop_idx] = pwdata[`BITOP_VAL_BIT];
      mode_wval = mode_wval & `MODE_LIVE_MASK;
   end

   // Software is expected to write only a stop or an overflow clear while running;
   // the logic accepts any write and does not police that.
   always @* begin
      op_mode_nxt = op_mode_r;
      out_toggle_cond_nxt = out_toggle_cond_r;
      if (mode_any_wr) begin
         op_mode_nxt = mode_wval[`MODE_OP_HI:`MODE_OP_LO];
         out_toggle_cond_nxt = mode_wval[`MODE_OTC_BIT];
      end
   end

   // The flag has its own process: the wrap term depends on the next mode, and
   // sharing a process with the mode field would close a combinational loop.
   always @* begin
      overflow_flag_nxt = overflow_flag_r;
      // Writing 0 clears the flag; writing 1 sets it.
      if (mode_any_wr)
         overflow_flag_nxt = mode_wval[`MODE_OVF_BIT];
      // A stopped counter never holds an overflow.
      if (stop_next)
         overflow_flag_nxt = 1'b0;
      // A wrap in the very cycle of a clearing write still sets the flag.
      if (wrap_evt)
         overflow_flag_nxt = 1'b1;
   end

   always @(posedge core_clk) begin
      if (!resetn) begin
         // Reset leaves the counter stopped.
         op_mode_r <= 2'h0;
         out_toggle_cond_r <= 1'b0;
         overflow_flag_r <= 1'b0;
      end else begin
         op_mode_r <= op_mode_nxt;
         out_toggle_cond_r <= out_toggle_cond_nxt;
         overflow_flag_r <= overflow_flag_nxt;
      end
   end

   // Compare and prescaler registers.

   // Compare values are taken at any time; keeping them stable while running is
   // left to software, as the match logic compares them every cycle.
   always @(posedge core_clk) begin
      if (!resetn) begin
         compare_reg_a_r <= 16'h0000;
         compare_reg_b_r <= 16'h0000;
         prescaler_mode_reg_r <= `PRM_RESET;
      end else begin
         if (cmp_a_wr)
            compare_reg_a_r <= pwdata[15:0];
         if (cmp_b_wr)
            compare_reg_b_r <= pwdata[15:0];
         // Bits other than the edge select are stored only for readback.
         if (prescaler_wr)
            prescaler_mode_reg_r <= pwdata[7:0];
      end
   end

   // External edge detection.

   // The valid edge is chosen by the prescaler edge-select field.
   // A code with no valid edge leaves the edge clear and the edge toggle idle.
   assign edge_sel = prescaler_mode_reg_r[`PRM_ES_HI:`PRM_ES_LO];

   input_edge_detect input_edge_detect_inst (
      .core_clk(core_clk),
      .resetn(resetn),
      .sig_in(ext_timer_input),
      .edge_sel(edge_sel),
      .edge_evt(edge_evt)
   );

   // Counter.

   // The count advances in every cycle in which the mode field holds a nonzero value and no clear event or stop write loads zero;
   // with the field at zero the counter receives no count enable at all.
   assign running = (op_mode_r != `OPM_STOP);
   assign match_a = running && (timer_count_r == compare_reg_a_r);
   assign match_b = running && (timer_count_r == compare_reg_b_r);

   // The increment rolls over from the maximum back to zero by itself.
   assign count_inc = timer_count_r + 16'h0001;
   assign at_max = (timer_count_r == `COUNT_MAX);
   // Stopping takes effect at the edge of the stop write itself.
   assign stop_next = (op_mode_nxt == `OPM_STOP);

   // Which clear-and-start source, if any, the present mode listens to.
   always @* begin
      edge_clr_mode = 1'b0;
      match_clr_mode = 1'b0;
      case (op_mode_r)
         `OPM_EDGE_CLR: edge_clr_mode = 1'b1;
         `OPM_MATCH_CLR: match_clr_mode = 1'b1;
         default: edge_clr_mode = 1'b0;
      endcase
   end

   assign clear_evt = (edge_clr_mode && edge_evt) || (match_clr_mode && match_a);

   // A clear-and-start from the maximum value is a restart, not an overflow.
   assign wrap_evt = running && !clear_evt && !stop_next && at_max;

   always @* begin
      timer_count_nxt = timer_count_r;
      case (op_mode_r)
         `OPM_STOP: timer_count_nxt = 16'h0000;
         `OPM_FREE: timer_count_nxt = count_inc;
         `OPM_EDGE_CLR,
         `OPM_MATCH_CLR: begin
            if (clear_evt)
               timer_count_nxt = 16'h0000;
            else
               timer_count_nxt = count_inc;
         end
         default: timer_count_nxt = 16'h0000;
      endcase
      // A write of the stop code empties the counter at once.
      if (stop_next)
         timer_count_nxt = 16'h0000;
   end

   always @(posedge core_clk) begin
      if (!resetn)
         timer_count_r <= 16'h0000;
      else
         timer_count_r <= timer_count_nxt;
   end

   // Timer output.

   // Matches always toggle the pin; the external edge joins only with the
   // condition bit set.
   assign edge_toggle = out_toggle_cond_r && running && edge_evt;
   assign toggle_evt = match_a || match_b || edge_toggle;

   always @* begin
      timer_output_nxt = timer_output;
      if (toggle_evt)
         timer_output_nxt = ~timer_output;
   end

   always @(posedge core_clk) begin
      if (!resetn)
         timer_output <= 1'b0;
      else
         timer_output <= timer_output_nxt;
   end

   // Interrupts.

   assign events[`EV_OVF] = wrap_evt;
   assign events[`EV_MATCH_A] = match_a;
   assign events[`EV_MATCH_B] = match_b;
   // The edge event counts only while running, so a stopped timer raises nothing.
   assign events[`EV_EDGE] = running && edge_evt;

   event_irq_ctrl #(
      .N(`EV_COUNT)
   ) event_irq_ctrl_inst (
      .core_clk(core_clk),
      .resetn(resetn),
      .evt(events),
      .clr_wr(irq_clr_wr),
      .en_wr(irq_en_wr),
      .wdata(pwdata[`EV_COUNT-1:0]),
      .status_r(irq_status),
      .enable_r(irq_enable),
      .irq(irq)
   );

   // Read data.

   // Read data is captured in the setup cycle so that it leaves a flip-flop and
   // stands stable through the access cycle.
   always @* begin
      case (paddr)
         `ADDR_MODE_CTRL: rdata_nxt = {24'h000000, mode_byte};
         `ADDR_CMP_A: rdata_nxt = {16'h0000, compare_reg_a_r};
         `ADDR_CMP_B: rdata_nxt = {16'h0000, compare_reg_b_r};
         `ADDR_PRESCALER: rdata_nxt = {24'h000000, prescaler_mode_reg_r};
         `ADDR_COUNT: rdata_nxt = {16'h0000, timer_count_r};
         `ADDR_IRQ_STATUS: rdata_nxt = {28'h0000000, irq_status};
         `ADDR_IRQ_ENABLE: rdata_nxt = {28'h0000000, irq_enable};
         // The write-only bit-update and clear registers read as zero.
         `ADDR_MODE_BITOP,
         `ADDR_IRQ_CLEAR: rdata_nxt = 32'h00000000;
         default: rdata_nxt = 32'h00000000;
      endcase
   end

   always @(posedge core_clk) begin
      if (!resetn)
         prdata <= 32'h00000000;
      else if (rd_setup)
         prdata <= rdata_nxt;
   end

endmodule // timer_mode_control

//--- hw/timer_mode_defs.vh
// Register map, field positions, reset values and encodings of the timer mode block.
// Included by the timer and edge detector design files and by the bench; holds definitions only.
`ifndef TIMER_MODE_DEFS_VH
`define TIMER_MODE_DEFS_VH

// Byte addresses on the APB register bus.
`define ADDR_MODE_CTRL 8'h00
`define ADDR_MODE_BITOP 8'h04
`define ADDR_CMP_A 8'h08
`define ADDR_CMP_B 8'h0C
`define ADDR_PRESCALER 8'h10
`define ADDR_COUNT 8'h14
`define ADDR_IRQ_STATUS 8'h18
`define ADDR_IRQ_CLEAR 8'h1C
`define ADDR_IRQ_ENABLE 8'h20

// Fields of the mode control register.
`define MODE_OVF_BIT 0
`define MODE_OTC_BIT 1
`define MODE_OP_LO 2
`define MODE_OP_HI 3
`define MODE_LIVE_MASK 8'h0F
`define MODE_RESET 8'h00

// Fields of the single-bit update register.
`define BITOP_IDX_HI 2
`define BITOP_VAL_BIT 8

// Edge select field of the prescaler mode register.
`define PRM_ES_LO 4
`define PRM_ES_HI 5
`define PRM_RESET 8'h00

// Operating-mode encodings.
`define OPM_STOP 2'h0
`define OPM_FREE 2'h1
`define OPM_EDGE_CLR 2'h2
`define OPM_MATCH_CLR 2'h3

// Edge select encodings.
`define ES_FALL 2'h0
`define ES_RISE 2'h1
`define ES_NONE 2'h2
`define ES_BOTH 2'h3

// Interrupt event bit positions.
`define EV_OVF 0
`define EV_MATCH_A 1
`define EV_MATCH_B 2
`define EV_EDGE 3
`define EV_COUNT 4

`define COUNT_MAX 16'hFFFF

`endif

//--- hw/input_edge_detect.v
// Valid-edge detector for the external timer input.
// Assumes the input is already synchronous to core_clk.
`timescale 1ns/1ps
`include "timer_mode_defs.vh"

module input_edge_detect (
   // Clock and reset.
   input wire core_clk,
   input wire resetn,
   // Input and edge selection.
   input wire sig_in,
   input wire [1:0] edge_sel,
   // One-cycle pulse on a selected edge.
   output reg edge_evt
);
   reg prev_r;
   reg primed_r;
   reg edge_nxt;

   // The first sample after reset only primes the history, so no false edge is seen.
   always @(posedge core_clk) begin
      if (!resetn) begin
         prev_r <= 1'b0;
         primed_r <= 1'b0;
      end else begin
         prev_r <= sig_in;
         primed_r <= 1'b1;
      end
   end

   always @* begin
      case (edge_sel)
         `ES_FALL: edge_nxt = prev_r & ~sig_in;
         `ES_RISE: edge_nxt = ~prev_r & sig_in;
         `ES_BOTH: edge_nxt = prev_r ^ sig_in;
         default: edge_nxt = 1'b0;
      endcase
      edge_evt = primed_r & edge_nxt;
   end
endmodule // input_edge_detect

//--- hw/event_irq_ctrl.v
// Sticky event status, write-one-to-clear, enable mask and one level interrupt.
// Assumes event pulses and register writes come from the same core_clk domain.
`timescale 1ns/1ps

module event_irq_ctrl #(
   parameter N = 4
) (
   // Clock and reset.
   input wire core_clk,
   input wire resetn,
   // Event pulses.
   input wire [N-1:0] evt,
   // Register writes.
   input wire clr_wr,
   input wire en_wr,
   input wire [N-1:0] wdata,
   // State and interrupt.
   output reg [N-1:0] status_r,
   output reg [N-1:0] enable_r,
   output wire irq
);
   genvar i;

   // A new event in the cycle of its clear keeps the bit set.
   generate
      for (i = 0; i < N; i = i + 1) begin : g_bit
         always @(posedge core_clk) begin
            if (!resetn) begin
               status_r[i] <= 1'b0;
               enable_r[i] <= 1'b0;
            end else begin
               if (evt[i])
                  status_r[i] <= 1'b1;
               else if (clr_wr && wdata[i])
                  status_r[i] <= 1'b0;
               if (en_wr)
                  enable_r[i] <= wdata[i];
            end
         end
      end
   endgenerate

   assign irq = |(status_r & enable_r);
endmodule // event_irq_ctrl

//--- dv/timer_mode_control_monitor.sv
// Port-level checker of the timer mode block.
// Assumes the APB register map of the block and a single core_clk domain.
`timescale 1ns/1ps
`include "timer_mode_defs.vh"
module timer_mode_control_monitor (
   // Clock and reset.
   input wire core_clk,
   input wire resetn,
   // APB.
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   // Pins and interrupt.
   input wire ext_timer_input,
   input wire timer_output,
   input wire irq
);
   // Software view of mode bits 3..1; the overflow bit is left out because hardware moves it.
   logic [3:1] mode_r;
   logic [3:0] en_r;
   wire wr = psel && penable && pwrite;
   wire rd = psel && !penable && !pwrite;
   always @(posedge core_clk) begin
      if (!resetn) begin
         mode_r <= 3'h0;
         en_r <= 4'h0;
      end else begin
         if (wr && paddr == `ADDR_MODE_CTRL) begin
            mode_r <= pwdata[3:1];
         end else if (wr && paddr == `ADDR_MODE_BITOP && pwdata[2:0] != 3'h0 &&
                      pwdata[2:0] < 3'h4) begin
            mode_r[pwdata[1:0]] <= pwdata[`BITOP_VAL_BIT];
         end
         if (wr && paddr == `ADDR_IRQ_ENABLE) begin
            en_r <= pwdata[3:0];
         end
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   reset_quiet_a: assert property ($rose(resetn) |-> !timer_output && !irq)
      else $error("outputs not low after reset");
   mode_readback_a: assert property (rd && paddr == `ADDR_MODE_CTRL |=> prdata[3:1] == mode_r)
      else $error("mode register readback wrong");
   upper_zero_a: assert property (rd && paddr == `ADDR_MODE_CTRL |=> prdata[31:4] == 28'h0)
      else $error("upper mode bits not zero");
   stop_ovf_a: assert property (rd && paddr == `ADDR_MODE_CTRL && mode_r[3:2] == 2'h0 |=> !prdata[0])
      else $error("overflow flag set while stopped");
   stop_count_a: assert property (rd && paddr == `ADDR_COUNT && mode_r[3:2] == 2'h0 |=> prdata == 32'h0)
      else $error("count not zero while stopped");
   stop_hold_a: assert property (mode_r[3:2] == 2'h0 |=> $stable(timer_output))
      else $error("output moved while stopped");
   irq_masked_a: assert property (en_r == 4'h0 |-> !irq)
      else $error("interrupt with all sources masked");
   err_unmapped_a: assert property (psel && penable && paddr > `ADDR_IRQ_ENABLE |-> pslverr)
      else $error("no error on unmapped address");
   err_access_a: assert property (pslverr |-> psel && penable)
      else $error("error outside access phase");
   ready_access_a: assert property (psel && penable |-> pready)
      else $error("no ready in access phase");
endmodule // timer_mode_control_monitor

bind timer_mode_control timer_mode_control_monitor timer_mode_control_monitor_inst (
   .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .ext_timer_input(ext_timer_input), .timer_output(timer_output), .irq(irq));

//--- dv/timer_mode_control_tb_top.sv
// Self-checking bench of the timer mode block: APB master tasks, one task per scenario.
// Assumes the block's register map and a 250 MHz core_clk.
`timescale 1ns/1ps
`include "timer_mode_defs.vh"
module timer_mode_control_tb_top;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic ext_timer_input = 1'b0;
   logic [31:0] prdata;
   logic [31:0] q;
   logic pready, pslverr, timer_output, irq, err;
   int errors = 0;
   int n_checks = 0;
   int n_tog = 0;
   int cyc = 0;
   timer_mode_control timer_mode_control_inst (.core_clk(core_clk), .resetn(resetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_timer_input(ext_timer_input),
      .timer_output(timer_output), .irq(irq));
   initial begin
      forever #2 core_clk = ~core_clk;
   end
   always @(timer_output) if (resetn === 1'b1) n_tog++;
   // A wrap of the counter takes 65536 cycles, so the ceiling leaves room for one.
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 90000) begin
         errors++;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic pulse();
      repeat (3) @(posedge core_clk);
      ext_timer_input <= 1'b1;
      repeat (6) @(posedge core_clk);
      ext_timer_input <= 1'b0;
      repeat (6) @(posedge core_clk);
   endtask
   task automatic t_regs();
      apb(0, `ADDR_MODE_CTRL, 32'h0);
      chk(q, 32'h0);
      apb(1, `ADDR_MODE_CTRL, 32'hF2);
      apb(0, `ADDR_MODE_CTRL, 32'h0);
      chk(q, 32'h2);
      apb(1, `ADDR_MODE_BITOP, 32'h1);
      apb(0, `ADDR_MODE_CTRL, 32'h0);
      chk(q, 32'h0);
      apb(0, 8'h40, 32'h0);
      chk({q[31:1], err}, 32'h1);
      $display("t_regs done");
   endtask
   task automatic t_overflow();
      int w;
      w = 0;
      apb(1, `ADDR_IRQ_ENABLE, 32'h1);
      apb(1, `ADDR_MODE_CTRL, 32'h4);
      apb(0, `ADDR_COUNT, 32'h0);
      chk({31'h0, q > 32'h0}, 32'h1);
      while (irq !== 1'b1 && w < 70000) begin
         @(posedge core_clk);
         w++;
      end
      apb(0, `ADDR_MODE_CTRL, 32'h0);
      chk(q, 32'h5);
      apb(1, `ADDR_MODE_CTRL, 32'h4);
      apb(0, `ADDR_MODE_CTRL, 32'h0);
      chk(q, 32'h4);
      apb(1, `ADDR_IRQ_CLEAR, 32'h1);
      @(posedge core_clk);
      chk({31'h0, irq}, 32'h0);
      apb(1, `ADDR_MODE_CTRL, 32'h0);
      apb(0, `ADDR_COUNT, 32'h0);
      chk(q, 32'h0);
      $display("t_overflow done");
   endtask
   task automatic t_match();
      apb(1, `ADDR_CMP_A, 32'h10);
      apb(1, `ADDR_CMP_B, 32'h20);
      apb(1, `ADDR_IRQ_CLEAR, 32'hF);
      n_tog = 0;
      apb(1, `ADDR_MODE_CTRL, 32'h4);
      repeat (48) @(posedge core_clk);
      apb(1, `ADDR_MODE_CTRL, 32'h0);
      chk(n_tog, 2);
      apb(0, `ADDR_IRQ_STATUS, 32'h0);
      chk(q, 32'h6);
      apb(1, `ADDR_CMP_A, 32'h8);
      n_tog = 0;
      apb(1, `ADDR_MODE_CTRL, 32'hC);
      repeat (40) @(posedge core_clk);
      apb(0, `ADDR_COUNT, 32'h0);
      apb(1, `ADDR_MODE_CTRL, 32'h0);
      chk({31'h0, q < 32'h9}, 32'h1);
      chk({31'h0, n_tog > 3}, 32'h1);
      $display("t_match done");
   endtask
   task automatic t_edge();
      apb(1, `ADDR_CMP_A, 32'hFFFF);
      apb(1, `ADDR_CMP_B, 32'hFFFF);
      apb(1, `ADDR_MODE_CTRL, 32'hA);
      for (int i = 0; i < 4; i++) begin
         apb(1, `ADDR_PRESCALER, {26'h0, i[1:0], 4'h0});
         n_tog = 0;
         pulse();
         chk(n_tog, (i == 3) ? 2 : (i == 2) ? 0 : 1);
      end
      apb(0, `ADDR_COUNT, 32'h0);
      chk({31'h0, q < 32'h10}, 32'h1);
      apb(1, `ADDR_MODE_CTRL, 32'h0);
      apb(1, `ADDR_MODE_CTRL, 32'h8);
      n_tog = 0;
      pulse();
      chk(n_tog, 0);
      apb(1, `ADDR_MODE_CTRL, 32'h0);
      $display("t_edge done");
   endtask
   initial begin
      repeat (8) @(posedge core_clk);
      resetn <= 1'b1;
      t_regs();
      t_overflow();
      t_match();
      t_edge();
      complete_run();
   end
endmodule // timer_mode_control_tb_top
